// ### src/prc_pkg.sv
// constants and types of the power, reset and clock controller
// Behaviour
// R1 - low battery register: threshold 7:3, source bit 2, bit 1 unused, flag bit 0
// R2 - threshold is plain binary, 32 levels, 0 lowest, 31 highest
// R3 - a reset sequence returns every block register to its reset value; the code keeps the clock source select through it
// R4 - the system clock restarts only after the start-up delay
// R5 - power-on, brown-out, watchdog or external reset each start a reset
// R6 - external reset is active low, held low 2 ms by the outside
// R7 - internal mode divides the 2 MHz oscillator by two
// R8 - oscillator runs except in halt or with an external source
// R9 - two-bit source select: internal, square, crystal, reserved
// R10 - external square clock is used undivided
// R11 - crystal mode takes clock input, drives crystal output on gpio zero
// R12 - halt bit 0 of mode register enters halt, write-only, self-clears
// R13 - halt stops the oscillator, low-battery and brown-out circuits
// R14 - only the wakeup circuit ends halt
// R15 - after halt wake, wait 1 ms before execution resumes
// R16 - software writes the mode clear register after halt or idle
// R17 - idle bit 1 of mode register enters idle, write-only, self-clears
// R18 - idle keeps oscillator, watchdog, timer running; others shut down
// R19 - idle wakes on each timer overflow every 8192 cycles
// R20 - software disables the wakeup circuit before idle
// R21 - idle wake resumes the core next cycle, no start-up delay
// R22 - low battery flag read-only, 1 while below threshold
// R23 - source select 1 monitors the sense pin, 0 the supply
// R24 - flag is synchronised and held at 0 while the circuit is off
package prc_pkg;
  localparam logic [7:0] ADDR_LBC = 8'h00;
  localparam logic [7:0] ADDR_PMODE = 8'h04;
  localparam logic [7:0] ADDR_PMC = 8'h08;
  localparam logic [7:0] ADDR_CLKCFG = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam int LBC_THR_LSB = 3;
  localparam int LBC_SRC_BIT = 2;
  localparam int LBC_FLAG_BIT = 0;
  localparam int PM_HALT_BIT = 0;
  localparam int PM_IDLE_BIT = 1;
  localparam int ST_PMC_BIT = 8;
  localparam logic [4:0] THR_RST = 5'h00;
  localparam logic SRC_RST = 1'b0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int SYS_CLK_MHZ = 200;
  localparam int START_DELAY_NS = 1_000_000;
  localparam int EXT_RST_MIN_NS = 2_000_000;
  localparam int START_DELAY_CYC = (START_DELAY_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int IDLE_WAKE_CYC = 8192;
  localparam int START_W = 18;
  localparam int TIMER_W = 13;
  typedef enum logic [1:0] {
    CLK_INTERNAL = 2'h0,
    CLK_SQUARE = 2'h1,
    CLK_CRYSTAL = 2'h2,
    CLK_RESERVED = 2'h3
  } prc_clksel_e;
  typedef enum logic [4:0] {
    ST_RESET = 5'h01,
    ST_START = 5'h02,
    ST_RUN = 5'h04,
    ST_HALT = 5'h08,
    ST_IDLE = 5'h10
  } prc_state_e;
endpackage

// ### src/prc_power_reset_clock_ctrl.sv
// power, reset and clock controller with its axi4-lite register slave
`timescale 1ns/100ps
module prc_power_reset_clock_ctrl #(
  parameter int STARTUP_CYCLES = prc_pkg::START_DELAY_CYC, // start-up wait
  parameter int IDLE_WAKE_CYCLES = prc_pkg::IDLE_WAKE_CYC // timer period
) (
  input wire logic sys_clk, // 200 MHz
  input wire logic sys_rst, // async, high
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte enables
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic por_detect, // power-on detector
  input wire logic bor_detect, // brown-out comparator
  input wire logic watchdog_expire, // watchdog timeout
  input wire logic ext_reset_n, // external reset pin
  input wire logic osc_clk_in, // 2 MHz oscillator level
  input wire logic external_clock_in, // clock input pin level
  input wire logic multi_input_wakeup, // wake event
  input wire logic lb_cmp_supply, // comparator on supply
  input wire logic lb_cmp_pin, // comparator on sense pin
  input wire logic lb_fuse_en, // low battery enabled
  input wire logic bor_fuse_en, // brown-out enabled
  output logic core_run, // core may execute
  output logic io_reset, // i/o registers held in reset
  output logic osc_enable, // oscillator powered
  output logic lb_enable, // low battery circuit powered
  output logic bor_enable, // brown-out circuit powered
  output logic sys_tick, // one system clock cycle
  output logic [4:0] battery_threshold_select, // to reference
  output logic comparator_source_select, // to input mux
  output logic low_battery_flag, // below threshold
  output logic gpio_zero_out, // crystal output level
  output logic gpio_zero_oe // crystal output drive
);
  prc_pkg::prc_state_e state_r;
  prc_pkg::prc_state_e state_nxt;
  prc_pkg::prc_clksel_e clk_sel_r;
  logic rst_src;
  logic [prc_pkg::START_W-1:0] start_cnt_r;
  logic start_done;
  logic [prc_pkg::TIMER_W-1:0] tmr_cnt_r;
  logic tmr_ovf;
  logic halt_req_r;
  logic idle_req_r;
  logic pmc_pending_r;
  logic [4:0] thr_r;
  logic src_r;
  logic osc_q_r;
  logic ext_q_r;
  logic div_r;
  logic osc_edge;
  logic ext_edge;
  logic clk_tick;
  logic lb_s1_r;
  logic lb_s2_r;
  logic lb_mux;
  logic lb_en_nxt;
  logic bor_en_nxt;
  logic mode_exit;
  logic aw_full_r;
  logic w_full_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic wr_go;
  logic wr_byte0;
  logic wr_mapped;
  logic [31:0] rd_val;
  logic rd_err;

  // reset sources; watchdog is stopped in halt, brown-out when unpowered
  assign rst_src = por_detect | (bor_detect & bor_enable) |
    (watchdog_expire & (state_r != prc_pkg::ST_HALT)) | ~ext_reset_n; // [R5]
  assign start_done = start_cnt_r ==
    prc_pkg::START_W'(STARTUP_CYCLES - 1);
  assign tmr_ovf = clk_tick &&
    (tmr_cnt_r == prc_pkg::TIMER_W'(IDLE_WAKE_CYCLES - 1));
  assign mode_exit = (state_r == prc_pkg::ST_HALT ||
    state_r == prc_pkg::ST_IDLE) && state_nxt != state_r;

  // power state sequencing; any reset source overrides all states
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      prc_pkg::ST_RESET:
        if (!rst_src)
          state_nxt = prc_pkg::ST_START;
      prc_pkg::ST_START:
        if (start_done)
          state_nxt = prc_pkg::ST_RUN; // [R4] [R15]
      prc_pkg::ST_RUN:
        if (halt_req_r)
          state_nxt = prc_pkg::ST_HALT; // [R12]
        else if (idle_req_r)
          state_nxt = prc_pkg::ST_IDLE; // [R17]
      prc_pkg::ST_HALT:
        if (multi_input_wakeup)
          state_nxt = prc_pkg::ST_START; // [R14]
      prc_pkg::ST_IDLE:
        // wakeup circuit is ignored here, software keeps it off
        if (tmr_ovf)
          state_nxt = prc_pkg::ST_RUN; // [R19] [R21] [R20]
    endcase
    if (rst_src)
      state_nxt = prc_pkg::ST_RESET; // [R5]
  end

  // circuits shut down in halt and idle
  assign lb_en_nxt = lb_fuse_en && (state_nxt == prc_pkg::ST_RUN ||
    state_nxt == prc_pkg::ST_START); // [R13] [R18]
  assign bor_en_nxt = bor_fuse_en && state_nxt != prc_pkg::ST_HALT &&
    state_nxt != prc_pkg::ST_IDLE; // [R13] [R18]

  // state register and power control outputs
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_r <= prc_pkg::ST_RESET;
      core_run <= 1'b0;
      io_reset <= 1'b1;
      osc_enable <= 1'b0;
      lb_enable <= 1'b0;
      bor_enable <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      core_run <= state_nxt == prc_pkg::ST_RUN;
      io_reset <= state_nxt == prc_pkg::ST_RESET; // [R3]
      osc_enable <= state_nxt != prc_pkg::ST_HALT &&
        clk_sel_r == prc_pkg::CLK_INTERNAL; // [R8] [R13] [R18]
      lb_enable <= lb_en_nxt;
      bor_enable <= bor_en_nxt;
    end
  end

  // start-up delay counter, cleared outside the start-up state
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      start_cnt_r <= '0;
    else if (state_r == prc_pkg::ST_START && !start_done)
      start_cnt_r <= start_cnt_r + 1'b1; // [R4] [R15]
    else
      start_cnt_r <= '0;
  end

  // clock source edges; inputs arrive synchronous to sys_clk
  assign osc_edge = osc_clk_in & ~osc_q_r;
  assign ext_edge = external_clock_in & ~ext_q_r;
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      osc_q_r <= 1'b0;
      ext_q_r <= 1'b0;
      div_r <= 1'b0;
    end
    else
    begin
      osc_q_r <= osc_clk_in;
      ext_q_r <= external_clock_in;
      if (osc_edge && osc_enable)
        div_r <= ~div_r; // [R7]
    end
  end

  // one tick per system clock cycle of the chosen source
  always_comb
  begin
    unique case (clk_sel_r)
      prc_pkg::CLK_INTERNAL:
        clk_tick = osc_edge & div_r & osc_enable; // [R7] [R9]
      prc_pkg::CLK_SQUARE:
        clk_tick = ext_edge; // [R10]
      prc_pkg::CLK_CRYSTAL:
        clk_tick = ext_edge; // [R11]
      prc_pkg::CLK_RESERVED:
        clk_tick = 1'b0; // [R9]
    endcase
  end

  // core clock is held still until the sequence reaches run
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sys_tick <= 1'b0;
      gpio_zero_out <= 1'b0;
      gpio_zero_oe <= 1'b0;
    end
    else
    begin
      sys_tick <= clk_tick && state_r == prc_pkg::ST_RUN; // [R4]
      gpio_zero_oe <= clk_sel_r == prc_pkg::CLK_CRYSTAL; // [R11]
      gpio_zero_out <= clk_sel_r == prc_pkg::CLK_CRYSTAL &&
        !external_clock_in; // [R11]
    end
  end

  // timer keeps counting through idle, cleared in halt, reset and start-up
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      tmr_cnt_r <= '0;
    else if (state_r != prc_pkg::ST_RUN && state_r != prc_pkg::ST_IDLE)
      tmr_cnt_r <= '0;
    else if (tmr_ovf)
      tmr_cnt_r <= '0; // [R19]
    else if (clk_tick)
      tmr_cnt_r <= tmr_cnt_r + 1'b1; // [R18]
  end

  // low battery comparator: select, synchronise, gate when unpowered
  assign lb_mux = src_r ? lb_cmp_pin : lb_cmp_supply; // [R23]
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      lb_s1_r <= 1'b0;
      lb_s2_r <= 1'b0;
      low_battery_flag <= 1'b0;
    end
    else
    begin
      lb_s1_r <= lb_mux;
      lb_s2_r <= lb_s1_r; // [R24]
      low_battery_flag <= lb_s2_r & lb_en_nxt; // [R22] [R24]
    end
  end

  // write channel acceptance, address and data in either order
  assign wr_go = aw_full_r & w_full_r & ~s_axi_bvalid;
  assign wr_byte0 = wr_go & w_strb_r[0] & (state_r != prc_pkg::ST_RESET);
  assign wr_mapped = aw_addr_r == prc_pkg::ADDR_LBC ||
    aw_addr_r == prc_pkg::ADDR_PMODE || aw_addr_r == prc_pkg::ADDR_PMC ||
    aw_addr_r == prc_pkg::ADDR_CLKCFG || aw_addr_r == prc_pkg::ADDR_STATUS;
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= prc_pkg::RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_full_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      else if (wr_go)
        aw_full_r <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_full_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      else if (wr_go)
        w_full_r <= 1'b0;
      if (wr_go)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_mapped ? prc_pkg::RESP_OKAY :
          prc_pkg::RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        // ready only returns once the response is gone: one write at a time
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // software registers; the reset sequence restores them
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      thr_r <= prc_pkg::THR_RST;
      src_r <= prc_pkg::SRC_RST;
    end
    else if (state_r == prc_pkg::ST_RESET)
    begin
      thr_r <= prc_pkg::THR_RST; // [R3]
      src_r <= prc_pkg::SRC_RST; // [R3]
    end
    else if (wr_byte0 && aw_addr_r == prc_pkg::ADDR_LBC)
    begin
      thr_r <= w_data_r[prc_pkg::LBC_THR_LSB +: 5]; // [R1] [R2]
      src_r <= w_data_r[prc_pkg::LBC_SRC_BIT]; // [R1]
    end
  end
  assign battery_threshold_select = thr_r; // [R2]
  assign comparator_source_select = src_r;

  // clock source select lives through the reset sequence
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      clk_sel_r <= prc_pkg::CLK_INTERNAL;
    else if (wr_byte0 && aw_addr_r == prc_pkg::ADDR_CLKCFG)
      clk_sel_r <= prc_pkg::prc_clksel_e'(w_data_r[1:0]); // [R9]
  end

  // mode request bits, cleared by hardware when the mode ends
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      halt_req_r <= 1'b0;
      idle_req_r <= 1'b0;
    end
    else if (state_r == prc_pkg::ST_RESET)
    begin
      halt_req_r <= 1'b0; // [R3]
      idle_req_r <= 1'b0; // [R3]
    end
    else if (mode_exit)
    begin
      halt_req_r <= 1'b0; // [R12]
      idle_req_r <= 1'b0; // [R17]
    end
    else if (wr_byte0 && aw_addr_r == prc_pkg::ADDR_PMODE)
    begin
      if (w_data_r[prc_pkg::PM_HALT_BIT])
        halt_req_r <= 1'b1; // [R12]
      if (w_data_r[prc_pkg::PM_IDLE_BIT])
        idle_req_r <= 1'b1; // [R17]
    end
  end

  // pending clear after a wake; a wake in the clear cycle wins
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      pmc_pending_r <= 1'b0;
    else if (state_r == prc_pkg::ST_RESET)
      pmc_pending_r <= 1'b0;
    else if (mode_exit && !rst_src)
      pmc_pending_r <= 1'b1; // [R16]
    else if (wr_byte0 && aw_addr_r == prc_pkg::ADDR_PMC)
      pmc_pending_r <= 1'b0; // [R16]
  end

  // read decode; mode and clear registers are write-only
  always_comb
  begin
    rd_val = 32'h0000_0000;
    rd_err = 1'b0;
    unique case (s_axi_araddr)
      prc_pkg::ADDR_LBC:
      begin
        rd_val[prc_pkg::LBC_THR_LSB +: 5] = thr_r; // [R1]
        rd_val[prc_pkg::LBC_SRC_BIT] = src_r;
        rd_val[prc_pkg::LBC_FLAG_BIT] = low_battery_flag; // [R22]
      end
      prc_pkg::ADDR_PMODE, prc_pkg::ADDR_PMC:
        rd_val = 32'h0000_0000;
      prc_pkg::ADDR_CLKCFG:
        rd_val[1:0] = clk_sel_r;
      prc_pkg::ADDR_STATUS:
      begin
        rd_val[4:0] = state_r;
        rd_val[prc_pkg::ST_PMC_BIT] = pmc_pending_r;
      end
      default:
        rd_err = 1'b1;
    endcase
  end

  // read channel, data captured in the address cycle
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= prc_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= rd_err ? prc_pkg::RESP_SLVERR : prc_pkg::RESP_OKAY;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // checks
  property p_flag_shut;
    @(posedge sys_clk) disable iff (sys_rst)
    (state_r == prc_pkg::ST_HALT || state_r == prc_pkg::ST_IDLE)
      |-> !low_battery_flag;
  endproperty
  a_flag_shut: assert property (p_flag_shut) // [R24]
    else $error("low battery flag set while circuit is off");

  property p_halt_off;
    @(posedge sys_clk) disable iff (sys_rst)
    state_r == prc_pkg::ST_HALT |-> !osc_enable && !lb_enable &&
      !bor_enable && !core_run;
  endproperty
  a_halt_off: assert property (p_halt_off) // [R13]
    else $error("circuit left powered in halt");

  property p_halt_hold;
    @(posedge sys_clk) disable iff (sys_rst)
    state_r == prc_pkg::ST_HALT && !multi_input_wakeup && !rst_src
      |=> state_r == prc_pkg::ST_HALT;
  endproperty
  a_halt_hold: assert property (p_halt_hold) // [R14]
    else $error("halt ended without wake event");

  property p_start_len;
    @(posedge sys_clk) disable iff (sys_rst)
    $rose(core_run) && $past(state_r) == prc_pkg::ST_START |->
      $past(start_cnt_r) == prc_pkg::START_W'(STARTUP_CYCLES - 1);
  endproperty
  a_start_len: assert property (p_start_len) // [R15]
    else $error("start-up delay has wrong length");

  property p_idle_wake;
    @(posedge sys_clk) disable iff (sys_rst)
    state_r == prc_pkg::ST_IDLE && tmr_ovf && !rst_src
      |=> state_r == prc_pkg::ST_RUN && core_run && !idle_req_r;
  endproperty
  a_idle_wake: assert property (p_idle_wake) // [R21]
    else $error("idle wake did not resume next cycle");

  property p_idle_hold;
    @(posedge sys_clk) disable iff (sys_rst)
    state_r == prc_pkg::ST_IDLE && !tmr_ovf && !rst_src
      |=> state_r == prc_pkg::ST_IDLE && osc_enable ==
      (clk_sel_r == prc_pkg::CLK_INTERNAL);
  endproperty
  a_idle_hold: assert property (p_idle_hold) // [R19]
    else $error("idle ended without timer overflow");

  property p_reset;
    @(posedge sys_clk) disable iff (sys_rst)
    rst_src |=> io_reset && !core_run ##1 thr_r == prc_pkg::THR_RST &&
      !halt_req_r && !idle_req_r;
  endproperty
  a_reset: assert property (p_reset) // [R5]
    else $error("reset source did not reset the block");

  property p_halt_clear;
    @(posedge sys_clk) disable iff (sys_rst)
    state_r == prc_pkg::ST_HALT ##1 state_r == prc_pkg::ST_START
      |-> !halt_req_r && !core_run;
  endproperty
  a_halt_clear: assert property (p_halt_clear) // [R12]
    else $error("halt request not cleared on exit");

  property p_div;
    @(posedge sys_clk) disable iff (sys_rst)
    clk_sel_r == prc_pkg::CLK_INTERNAL && osc_enable && osc_edge &&
      state_r == prc_pkg::ST_RUN |=> sys_tick == $past(div_r);
  endproperty
  a_div: assert property (p_div) // [R7]
    else $error("internal clock not divided by two");

  property p_square;
    @(posedge sys_clk) disable iff (sys_rst)
    clk_sel_r == prc_pkg::CLK_SQUARE && ext_edge &&
      state_r == prc_pkg::ST_RUN |=> sys_tick;
  endproperty
  a_square: assert property (p_square) // [R10]
    else $error("square clock edge gave no tick");

  property p_xtal;
    @(posedge sys_clk) disable iff (sys_rst)
    clk_sel_r == prc_pkg::CLK_CRYSTAL |=> gpio_zero_oe &&
      gpio_zero_out == !$past(external_clock_in);
  endproperty
  a_xtal: assert property (p_xtal) // [R11]
    else $error("crystal output not driven");

  property p_rsvd;
    @(posedge sys_clk) disable iff (sys_rst)
    clk_sel_r == prc_pkg::CLK_RESERVED |=> !sys_tick;
  endproperty
  a_rsvd: assert property (p_rsvd) // [R9]
    else $error("reserved clock source gave a tick");
endmodule

// ### bench/prc_env_model.sv
// board-side model: oscillator, clock pin and reset pin
`timescale 1ns/100ps
module prc_env_model (
  input wire logic sys_clk, // bench clock
  input wire logic osc_enable, // oscillator power
  input wire logic ext_hold, // bench asks for external reset
  output logic osc_clk_in, // oscillator level
  output logic external_clock_in, // clock pin level
  output logic ext_reset_n // reset pin level
);
  int oc = 0;
  int ec = 0;
  initial osc_clk_in = 1'b0;
  initial external_clock_in = 1'b0;
  // oscillator, half period 3 cycles; frozen while unpowered
  always @(posedge sys_clk)
  begin
    if (osc_enable === 1'b1)
      oc <= (oc == 2) ? 0 : oc + 1;
    if (osc_enable === 1'b1 && oc == 2)
      osc_clk_in <= ~osc_clk_in;
  end
  // square clock pin, free running, half period 4 cycles
  always @(posedge sys_clk)
  begin
    ec <= (ec == 3) ? 0 : ec + 1;
    if (ec == 3)
      external_clock_in <= ~external_clock_in;
  end
  // pull-up keeps the pin high; bench holds it low for three cycles
  assign ext_reset_n = ~ext_hold;
endmodule

// ### bench/prc_power_reset_clock_ctrl_tb.sv
// self-checking bench for the power, reset and clock controller
`timescale 1ns/100ps
module prc_power_reset_clock_ctrl_tb;
  localparam int SU = 8;
  logic sys_clk, sys_rst, awv, wv, bre, arv, rre, por, bor, wdg, hold;
  logic wake, lbs, lbp, awr, wrdy, bv, arr, rv, run, iorst, osce, lbe;
  logic bore, tick, csel, flag, goe, go, oclk, eclk, ern, ep;
  logic [7:0] awa, ara;
  logic [31:0] wd, rdat;
  logic [1:0] br, rr;
  logic [4:0] thr, r;
  logic [34:0] exp_q[$];
  logic [1:0] bexp_q[$];
  int err_total = 0;
  int num_checks = 0;
  int seed = 32'ha7e29a8b;
  int n, i;
  int tk[4] = '{10, 15, 15, 0};

  prc_power_reset_clock_ctrl #(.STARTUP_CYCLES(SU), .IDLE_WAKE_CYCLES(8)) dut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(rre), .por_detect(por), .bor_detect(bor),
    .watchdog_expire(wdg), .ext_reset_n(ern), .osc_clk_in(oclk),
    .external_clock_in(eclk), .multi_input_wakeup(wake),
    .lb_cmp_supply(lbs), .lb_cmp_pin(lbp), .lb_fuse_en(1'b1),
    .bor_fuse_en(1'b1), .core_run(run), .io_reset(iorst),
    .osc_enable(osce), .lb_enable(lbe), .bor_enable(bore), .sys_tick(tick),
    .battery_threshold_select(thr), .comparator_source_select(csel),
    .low_battery_flag(flag), .gpio_zero_out(go), .gpio_zero_oe(goe));
  prc_env_model env (.sys_clk(sys_clk), .osc_enable(osce), .ext_hold(hold),
    .osc_clk_in(oclk), .external_clock_in(eclk), .ext_reset_n(ern));

  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic chk(string nm, logic [33:0] s, logic [33:0] e);
    num_checks++;
    if (s !== e)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  function automatic logic [34:0] ok(logic [31:0] d);
    return {3'b000, d};
  endfunction

  // write: both channels offered together, each dropped once taken
  task automatic wr(logic [7:0] a, logic [31:0] d,
    logic [1:0] e = prc_pkg::RESP_OKAY);
    @(posedge sys_clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    bexp_q.push_back(e);
    do
    begin
      @(posedge sys_clk);
      if (awr) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
    end
    while (bv !== 1'b1);
    bre <= 1'b0;
  endtask

  // read: the expectation is noted first, the monitor compares it
  task automatic rd(logic [7:0] a, logic [34:0] e);
    @(posedge sys_clk);
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    exp_q.push_back(e);
    do
    begin
      @(posedge sys_clk);
      if (arr) arv <= 1'b0;
    end
    while (rv !== 1'b1);
    rre <= 1'b0;
  endtask

  // bounded wait for the core, cycles counted in n
  task automatic wait_run;
    n = 0;
    while (run !== 1'b1 && n < 300)
    begin
      @(posedge sys_clk);
      n++;
    end
  endtask

  // monitor: the oldest note meets each answer; top bit = resp only
  always @(posedge sys_clk)
  begin
    if (rv === 1'b1 && rre === 1'b1)
    begin
      if (exp_q[0][34])
        chk("rresp", 34'(rr), 34'(exp_q[0][33:32]));
      else
        chk("rdata", {rr, rdat}, exp_q[0][33:0]);
      void'(exp_q.pop_front());
    end
    if (bv === 1'b1 && bre === 1'b1)
    begin
      chk("bresp", 34'(br), 34'(bexp_q[0]));
      void'(bexp_q.pop_front());
    end
  end

  // watchdog: whole run is about a thousand cycles
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    end_sim();
  end

  initial
  begin
    {sys_rst, por, bor, wdg, hold, wake, lbs, lbp} = 8'h80;
    {awv, wv, bre, arv, rre} = 5'h00;
    {awa, ara, wd} = 48'h0;
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    wait_run();
    chk("core_run", 34'(run), 34'h1);
    rd(8'h10, ok(32'h4));
    rd(8'h00, ok(32'h0));
    rd(8'h14, {1'b1, prc_pkg::RESP_SLVERR, 32'h0});
    wr(8'h18, 32'h0, prc_pkg::RESP_SLVERR);
    $display("test reset done");
    // end codes first, then random ones; written flag bit must not stick
    for (i = 0; i < 4; i++)
    begin
      r = (i == 0) ? 5'h00 : (i == 1) ? 5'h1f : 5'($random(seed));
      lbs <= 1'($random(seed));
      lbp <= 1'($random(seed));
      @(posedge sys_clk);
      wr(8'h00, {24'h0, r, 2'b10, ~lbp});
      repeat (6) @(posedge sys_clk);
      chk("thr", 34'({thr, csel, flag}), 34'({r, 1'b1, lbp}));
      rd(8'h00, ok({24'h0, r, 2'b10, lbp}));
      wr(8'h00, {24'h0, r, 3'b000});
      repeat (6) @(posedge sys_clk);
      rd(8'h00, ok({24'h0, r, 2'b00, lbs}));
    end
    $display("test low battery done");
    for (i = 0; i < 4; i++)
    begin
      wr(8'h0c, i);
      repeat (24) @(posedge sys_clk);
      n = 0;
      repeat (120) @(posedge sys_clk) n += (tick === 1'b1);
      chk("ticks", 34'(n), 34'(tk[i]));
      chk("crystal oe", 34'(goe), 34'(i == 2));
      ep = eclk;
      @(posedge sys_clk);
      chk("crystal out", 34'(go), 34'(i == 2 && !ep));
      rd(8'h0c, ok(i));
    end
    wr(8'h0c, 32'h0);
    $display("test clock done");
    wr(8'h04, 32'h1);
    repeat (2) @(posedge sys_clk);
    chk("halt", 34'({run, osce, lbe, bore}), 34'h0);
    wdg <= 1'b1;
    repeat (30) @(posedge sys_clk);
    wdg <= 1'b0;
    chk("halt held", 34'({run, iorst}), 34'h0);
    wake <= 1'b1;
    @(posedge sys_clk);
    wake <= 1'b0;
    wait_run();
    chk("startup", 34'(n >= SU && run === 1'b1), 34'h1);
    rd(8'h10, ok(32'h104));
    rd(8'h04, ok(32'h0));
    wr(8'h08, 32'h0);
    rd(8'h10, ok(32'h4));
    $display("test halt done");
    wr(8'h04, 32'h2); // wake input stays low through idle
    repeat (2) @(posedge sys_clk);
    chk("idle", 34'({run, osce, lbe, bore}), 34'h4);
    rd(8'h10, ok(32'h10));
    wait_run();
    chk("idle wake", 34'(run), 34'h1);
    rd(8'h10, ok(32'h104));
    wr(8'h08, 32'h0);
    $display("test idle done");
    // each of the four sources must restart the whole sequence
    for (i = 0; i < 4; i++)
    begin
      wr(8'h00, 32'hfc);
      @(posedge sys_clk);
      case (i)
        0: por <= 1'b1;
        1: bor <= 1'b1;
        2: wdg <= 1'b1;
        default: hold <= 1'b1;
      endcase
      repeat (3) @(posedge sys_clk);
      chk("io_reset", 34'({iorst, run}), 34'h2);
      {por, bor, wdg, hold} <= 4'h0;
      wait_run();
      chk("restart", 34'(n >= SU && run === 1'b1), 34'h1);
      rd(8'h00, ok({31'h0, lbs}));
    end
    $display("test reset sources done");
    end_sim();
  end
endmodule
